// ==== logic/spd_serial_dma.sv ====
`timescale 1ns/10ps
// Contract
// - each channel ping-pongs between buffers A and B
// - buffers are idle, pending or active
// - channel reset clears buffer states and counts
// - buffer spans start to inclusive end address
// - load bit hands buffer to the channel
// - end address writable while pending or active
// - count is offset of next byte, +1 per byte
// - tx shares one count, rx has two
// - count holds until reload or channel reset
// - rx count write on idle buffer loads it
// - unload when start plus count passes end
// - end or count writes also trigger unload check
// - two-bit mode: off, uart, spi, i2c
// - pending bits 12/11 for tx B/A unload
// - pending bits 10/9 for rx B/A unload
// - pending bits 14/13 parity and frame error
// - pending bits 8..5 for i2c events
// - pending bits 4/3 underrun and overrun
// - pending bits 2..0 idle, space, data
// - rx records offset of first errored byte
// - unload event on falling active indication, except on channel reset
module spd_serial_dma
    import spd_pkg::*;
#(
    parameter int SC_INDEX = 1,
    parameter int AW = 32,
    parameter int CW = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [AW-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic txf_valid,
    output logic [7:0] txf_data,
    input wire logic txf_ready,
    input wire logic rxf_valid,
    input wire logic [7:0] rxf_data,
    input wire logic rxf_perr,
    input wire logic rxf_ferr,
    output logic rxf_ready,
    input wire logic [IRQ_W-1:0] sc_event,
    output logic [1:0] serial_mode_field,
    output logic irq
);
    // per-controller address map
    localparam logic [15:0] PEND_ADR = (SC_INDEX == 1) ? OFS_PEND_ONE : OFS_PEND_TWO;
    localparam logic [15:0] EN_ADR = (SC_INDEX == 1) ? OFS_EN_ONE : OFS_EN_TWO;
    localparam logic [15:0] MODE_ADR = (SC_INDEX == 1) ? OFS_MODE_ONE : OFS_MODE_TWO;
    localparam logic [15:0] DMA_ADR = (SC_INDEX == 1) ? DMA_BASE_ONE : DMA_BASE_TWO;

    // address match inside the dma page
    function automatic logic hit(input logic [15:0] adr, input logic [7:0] ofs);
        hit = adr == DMA_ADR + {8'h00, ofs};
    endfunction : hit

    // unload test; one extra bit so the sum cannot wrap
    function automatic logic past_end(input logic [AW-1:0] beg, input logic [CW-1:0] cnt,
                                      input logic [AW-1:0] last);
        past_end = ({1'b0, beg} + (AW+1)'(cnt)) > {1'b0, last};
    endfunction : past_end

    spd_chan_if tx_if();
    spd_chan_if rx_if();

    logic [AW-1:0] tx_buffer_start_addr [2];
    logic [AW-1:0] tx_buffer_end_addr [2];
    logic [AW-1:0] rx_buffer_start_addr [2];
    logic [AW-1:0] rx_buffer_end_addr [2];
    logic [CW-1:0] tx_byte_offset;
    logic [CW-1:0] rx_byte_offset [2];
    logic [CW-1:0] rx_error_offset [2];
    logic rx_err_seen [2];
    spd_mode_t serial_mode_select;
    spd_mst_t mst;
    spd_buf_t tx_st [2];
    spd_buf_t rx_st [2];
    logic wr_acc;
    logic ctl_wr;
    logic rx_cnt_wr [2];
    logic rx_ld_ctl [2];
    logic run;
    logic tx_any;
    logic rx_any;
    logic tx_sel;
    logic rx_sel;
    logic wsel;
    logic rx_bad;
    logic tx_go;
    logic rx_go;
    logic tx_done;
    logic rx_done;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] pend;
    logic [IRQ_W-1:0] en;
    logic [31:0] rd_data;
    logic rd_hit;

    // state views as arrays so the per-buffer logic can loop
    assign tx_st[0] = tx_if.st_a;
    assign tx_st[1] = tx_if.st_b;
    assign rx_st[0] = rx_if.st_a;
    assign rx_st[1] = rx_if.st_b;

    // apb strobes; zero wait states, so a write lands on the access edge
    assign wr_acc = psel && penable && pwrite;
    assign ctl_wr = wr_acc && hit(paddr, OFS_CTRL);
    assign pready = 1'b1;

    // dma_control_reg bits are pulses and never stored
    assign tx_if.clr = ctl_wr && pwdata[CTL_TX_CHANNEL_RESET];
    assign rx_if.clr = ctl_wr && pwdata[CTL_RX_CHANNEL_RESET];
    assign tx_if.load_a = ctl_wr && pwdata[CTL_TX_BUFFER_LOAD];
    assign tx_if.load_b = ctl_wr && pwdata[CTL_TX_BUFFER_LOAD+1];
    assign rx_if.load_a = rx_ld_ctl[0] || (rx_cnt_wr[0] && rx_st[0] == BUF_IDLE);
    assign rx_if.load_b = rx_ld_ctl[1] || (rx_cnt_wr[1] && rx_st[1] == BUF_IDLE);

    // unload checks run every cycle, so register writes take effect at once
    assign tx_if.over_a = tx_st[0] == BUF_ACT
        && past_end(tx_buffer_start_addr[0], tx_byte_offset, tx_buffer_end_addr[0]);
    assign tx_if.over_b = tx_st[1] == BUF_ACT
        && past_end(tx_buffer_start_addr[1], tx_byte_offset, tx_buffer_end_addr[1]);
    assign rx_if.over_a = rx_st[0] != BUF_IDLE
        && past_end(rx_buffer_start_addr[0], rx_byte_offset[0], rx_buffer_end_addr[0]);
    assign rx_if.over_b = rx_st[1] != BUF_IDLE
        && past_end(rx_buffer_start_addr[1], rx_byte_offset[1], rx_buffer_end_addr[1]);

    spd_channel u_tx_chan (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ch(tx_if.chan)
    );

    spd_channel u_rx_chan (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ch(rx_if.chan)
    );

    // per-buffer address registers; end stays writable in every state
    for (genvar i = 0; i < 2; i++) begin : g_buf
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                tx_buffer_start_addr[i] <= AW'(WORD_RST);
                tx_buffer_end_addr[i] <= AW'(WORD_RST);
                rx_buffer_start_addr[i] <= AW'(WORD_RST);
                rx_buffer_end_addr[i] <= AW'(WORD_RST);
            end else begin
                if (wr_acc && hit(paddr, OFS_TXBEG[i])) begin
                    tx_buffer_start_addr[i] <= pwdata[AW-1:0];
                end
                if (wr_acc && hit(paddr, OFS_TXEND[i])) begin
                    tx_buffer_end_addr[i] <= pwdata[AW-1:0];
                end
                if (wr_acc && hit(paddr, OFS_RXBEG[i])) begin
                    rx_buffer_start_addr[i] <= pwdata[AW-1:0];
                end
                if (wr_acc && hit(paddr, OFS_RXEND[i])) begin
                    rx_buffer_end_addr[i] <= pwdata[AW-1:0];
                end
            end
        end

        // a load bit on a loaded buffer is ignored and keeps its count
        assign rx_cnt_wr[i] = wr_acc && hit(paddr, OFS_RXCNT[i]);
        assign rx_ld_ctl[i] = ctl_wr && pwdata[CTL_RX_BUFFER_LOAD+i] && rx_st[i] == BUF_IDLE;

        // rx counts: software write wins over a byte landing in the same cycle
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                rx_byte_offset[i] <= CW'(WORD_RST);
            end else if (rx_if.clr || rx_ld_ctl[i]) begin
                rx_byte_offset[i] <= CW'(WORD_RST);
            end else if (rx_cnt_wr[i]) begin
                rx_byte_offset[i] <= pwdata[CW-1:0];
            end else if (rx_done && wsel == 1'(i)) begin
                rx_byte_offset[i] <= rx_byte_offset[i] + CW'(1);
            end
        end

        // first errored byte only; cleared by reset or a fresh load
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                rx_err_seen[i] <= 1'b0;
                rx_error_offset[i] <= CW'(WORD_RST);
            end else if (rx_if.clr || (i == 0 ? rx_if.load_a : rx_if.load_b)) begin
                rx_err_seen[i] <= 1'b0;
            end else if (rx_done && wsel == 1'(i) && rx_bad && !rx_err_seen[i]) begin
                rx_err_seen[i] <= 1'b1;
                rx_error_offset[i] <= rx_byte_offset[i];
            end
        end
    end

    // shared tx count restarts whenever a buffer turns active
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_byte_offset <= CW'(WORD_RST);
        end else if (tx_if.clr || tx_if.activate) begin
            tx_byte_offset <= CW'(WORD_RST);
        end else if (tx_done) begin
            tx_byte_offset <= tx_byte_offset + CW'(1);
        end
    end

    // mode register; uart is refused on the second controller
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            serial_mode_select <= MODE_OFF;
        end else if (wr_acc && paddr == MODE_ADR) begin
            if (!(pwdata[1:0] == MODE_UART && SC_INDEX != 1)) begin
                serial_mode_select <= spd_mode_t'(pwdata[1:0]);
            end
        end
    end
    assign serial_mode_field = serial_mode_select;

    // channel run conditions; a disabled controller moves no data
    assign run = serial_mode_select != MODE_OFF;
    assign tx_any = tx_st[0] == BUF_ACT || tx_st[1] == BUF_ACT;
    assign rx_any = rx_st[0] == BUF_ACT && !rx_if.over_a || rx_st[1] == BUF_ACT && !rx_if.over_b;
    assign tx_sel = tx_st[1] == BUF_ACT;
    assign rx_sel = rx_st[1] == BUF_ACT;
    // rx is served first since a stalled receiver overruns
    assign rx_go = mst == M_IDLE && run && rx_any && rxf_valid;
    assign tx_go = mst == M_IDLE && run && tx_any && !rx_go;
    assign tx_done = mst == M_TXRD && mem_ack;
    assign rx_done = mst == M_RXWR && mem_ack;
    assign rxf_ready = rx_go;

    // one memory sequencer serves both channels, one byte at a time
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mst <= M_IDLE;
        end else begin
            case (mst)
                M_IDLE: begin
                    if (rx_go) begin
                        mst <= M_RXWR;
                    end else if (tx_go) begin
                        mst <= M_TXRD;
                    end
                end
                M_TXRD: begin
                    if (mem_ack) begin
                        mst <= M_TXPUSH;
                    end
                end
                M_TXPUSH: begin
                    if (txf_ready) begin
                        mst <= M_IDLE;
                    end
                end
                M_RXWR: begin
                    if (mem_ack) begin
                        mst <= M_IDLE;
                    end
                end
                default: begin
                    mst <= M_IDLE;
                end
            endcase
        end
    end

    // request address and data are latched at launch and held until ack
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= AW'(WORD_RST);
            mem_wdata <= 8'h00;
            rx_bad <= 1'b0;
            wsel <= 1'b0;
        end else if (rx_go) begin
            mem_addr <= rx_buffer_start_addr[rx_sel] + AW'(rx_byte_offset[rx_sel]);
            mem_wdata <= rxf_data;
            rx_bad <= rxf_perr || rxf_ferr;
            wsel <= rx_sel;
        end else if (tx_go) begin
            mem_addr <= tx_buffer_start_addr[tx_sel] + AW'(tx_byte_offset);
        end
    end

    // fetched byte waits here until the transmit fifo takes it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            txf_data <= 8'h00;
        end else if (tx_done) begin
            txf_data <= mem_rdata;
        end
    end

    assign mem_req = mst == M_TXRD || mst == M_RXWR;
    assign mem_we = mst == M_RXWR;
    assign txf_valid = mst == M_TXPUSH;

    // dma completion events replace the controller's own bits 9..12
    always_comb begin
        irq_set = sc_event & ~IRQ_DMA_MASK;
        irq_set[IRQ_RX_UNLOADED] = rx_if.unload_a;
        irq_set[IRQ_RX_UNLOADED+1] = rx_if.unload_b;
        irq_set[IRQ_TX_UNLOADED] = tx_if.unload_a;
        irq_set[IRQ_TX_UNLOADED+1] = tx_if.unload_b;
    end

    spd_irq_flags u_flags (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .set_ev(irq_set),
        .pend_wr(wr_acc && paddr == PEND_ADR),
        .en_wr(wr_acc && paddr == EN_ADR),
        .wdata(pwdata),
        .serial_irq_pending(pend),
        .serial_irq_enable(en),
        .irq(irq)
    );

    // read mux; control reads as zero, pending and enable bit 15 and above read as zero
    always_comb begin
        rd_data = WORD_RST;
        rd_hit = 1'b0;
        if (paddr == PEND_ADR) begin
            rd_data = 32'(pend);
            rd_hit = 1'b1;
        end
        if (paddr == EN_ADR) begin
            rd_data = 32'(en);
            rd_hit = 1'b1;
        end
        if (paddr == MODE_ADR) begin
            rd_data = 32'(serial_mode_select);
            rd_hit = 1'b1;
        end
        if (hit(paddr, OFS_TXCNT)) begin
            rd_data = 32'(tx_byte_offset);
            rd_hit = 1'b1;
        end
        if (hit(paddr, OFS_CTRL)) begin
            rd_hit = 1'b1;
        end
        if (hit(paddr, OFS_STAT)) begin
            rd_data = 32'({rx_err_seen[1], rx_err_seen[0],
                           rx_st[1] == BUF_PEND, rx_st[0] == BUF_PEND,
                           tx_st[1] == BUF_PEND, tx_st[0] == BUF_PEND,
                           rx_st[1] == BUF_ACT, rx_st[0] == BUF_ACT,
                           tx_st[1] == BUF_ACT, tx_st[0] == BUF_ACT});
            rd_hit = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (hit(paddr, OFS_TXBEG[i])) begin
                rd_data = 32'(tx_buffer_start_addr[i]);
                rd_hit = 1'b1;
            end
            if (hit(paddr, OFS_TXEND[i])) begin
                rd_data = 32'(tx_buffer_end_addr[i]);
                rd_hit = 1'b1;
            end
            if (hit(paddr, OFS_RXBEG[i])) begin
                rd_data = 32'(rx_buffer_start_addr[i]);
                rd_hit = 1'b1;
            end
            if (hit(paddr, OFS_RXEND[i])) begin
                rd_data = 32'(rx_buffer_end_addr[i]);
                rd_hit = 1'b1;
            end
            if (hit(paddr, OFS_RXCNT[i])) begin
                rd_data = 32'(rx_byte_offset[i]);
                rd_hit = 1'b1;
            end
            if (hit(paddr, OFS_RXERR[i])) begin
                rd_data = 32'(rx_error_offset[i]);
                rd_hit = 1'b1;
            end
        end
    end

    // unmapped addresses answer with an error and change nothing
    assign prdata = rd_data;
    assign pslverr = psel && penable && !rd_hit;
endmodule : spd_serial_dma

// ==== logic/spd_pkg.sv ====
package spd_pkg;
    // printed register offsets, one set per serial controller
    localparam logic [15:0] OFS_PEND_ONE = 16'hA808;
    localparam logic [15:0] OFS_PEND_TWO = 16'hA80C;
    localparam logic [15:0] OFS_EN_ONE = 16'hA848;
    localparam logic [15:0] OFS_EN_TWO = 16'hA84C;
    localparam logic [15:0] OFS_MODE_ONE = 16'hC854;
    localparam logic [15:0] OFS_MODE_TWO = 16'hC054;
    // dma register page, offsets relative to the page base
    localparam logic [15:0] DMA_BASE_ONE = 16'hC800;
    localparam logic [15:0] DMA_BASE_TWO = 16'hC000;
    localparam logic [7:0] OFS_TXBEG [2] = '{8'h00, 8'h08};
    localparam logic [7:0] OFS_TXEND [2] = '{8'h04, 8'h0C};
    localparam logic [7:0] OFS_RXBEG [2] = '{8'h10, 8'h18};
    localparam logic [7:0] OFS_RXEND [2] = '{8'h14, 8'h1C};
    localparam logic [7:0] OFS_TXCNT = 8'h20;
    localparam logic [7:0] OFS_RXCNT [2] = '{8'h24, 8'h28};
    localparam logic [7:0] OFS_CTRL = 8'h2C;
    localparam logic [7:0] OFS_STAT = 8'h30;
    localparam logic [7:0] OFS_RXERR [2] = '{8'h34, 8'h38};
    // control register bit positions (load bits a at n, b at n+1)
    localparam int CTL_TX_BUFFER_LOAD = 0;
    localparam int CTL_RX_BUFFER_LOAD = 2;
    localparam int CTL_TX_CHANNEL_RESET = 4;
    localparam int CTL_RX_CHANNEL_RESET = 5;
    // pending register layout (a at n, b at n+1)
    localparam int IRQ_W = 15;
    localparam int IRQ_RX_UNLOADED = 9;
    localparam int IRQ_TX_UNLOADED = 11;
    localparam logic [14:0] IRQ_DMA_MASK = 15'h1E00;
    localparam logic [14:0] IRQ_RST = 15'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0, MODE_UART = 2'h1, MODE_SPI = 2'h2, MODE_I2C = 2'h3
    } spd_mode_t;
    typedef enum logic [1:0] {BUF_IDLE = 2'h0, BUF_PEND = 2'h1, BUF_ACT = 2'h3} spd_buf_t;
    typedef enum logic [1:0] {
        M_IDLE = 2'h0, M_TXRD = 2'h1, M_TXPUSH = 2'h3, M_RXWR = 2'h2
    } spd_mst_t;
endpackage : spd_pkg

// ==== logic/spd_chan_if.sv ====
`timescale 1ns/10ps
interface spd_chan_if;
    import spd_pkg::*;
    logic load_a;
    logic load_b;
    logic clr;
    logic over_a;
    logic over_b;
    spd_buf_t st_a;
    spd_buf_t st_b;
    logic unload_a;
    logic unload_b;
    logic activate;
    modport ctl(output load_a, load_b, clr, over_a, over_b,
                input st_a, st_b, unload_a, unload_b, activate);
    modport chan(input load_a, load_b, clr, over_a, over_b,
                 output st_a, st_b, unload_a, unload_b, activate);
endinterface : spd_chan_if

// ==== logic/spd_channel.sv ====
`timescale 1ns/10ps
module spd_channel
    import spd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    spd_chan_if.chan ch
);
    spd_buf_t next_a;
    spd_buf_t next_b;

    // unload first, then promote the pending buffer, then accept loads
    always_comb begin
        next_a = ch.st_a;
        next_b = ch.st_b;
        if (ch.over_a) next_a = BUF_IDLE;
        if (ch.over_b) next_b = BUF_IDLE;
        if (next_a == BUF_PEND && next_b != BUF_ACT) next_a = BUF_ACT;
        if (next_b == BUF_PEND && next_a != BUF_ACT) next_b = BUF_ACT;
        if (ch.load_a && next_a == BUF_IDLE) begin
            next_a = (next_b == BUF_ACT) ? BUF_PEND : BUF_ACT;
        end
        if (ch.load_b && next_b == BUF_IDLE) begin
            next_b = (next_a == BUF_ACT) ? BUF_PEND : BUF_ACT;
        end
        if (ch.clr) begin
            next_a = BUF_IDLE;
            next_b = BUF_IDLE;
        end
    end

    // buffer state registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ch.st_a <= BUF_IDLE;
            ch.st_b <= BUF_IDLE;
        end else begin
            ch.st_a <= next_a;
            ch.st_b <= next_b;
        end
    end

    // a channel reset is not a completion, so it raises no unload event
    assign ch.unload_a = ch.st_a == BUF_ACT && next_a != BUF_ACT && !ch.clr;
    assign ch.unload_b = ch.st_b == BUF_ACT && next_b != BUF_ACT && !ch.clr;
    assign ch.activate = (next_a == BUF_ACT && ch.st_a != BUF_ACT)
                      || (next_b == BUF_ACT && ch.st_b != BUF_ACT);
endmodule : spd_channel

// ==== logic/spd_irq_flags.sv ====
`timescale 1ns/10ps
module spd_irq_flags
    import spd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [IRQ_W-1:0] set_ev,
    input wire logic pend_wr,
    input wire logic en_wr,
    input wire logic [31:0] wdata,
    output logic [IRQ_W-1:0] serial_irq_pending,
    output logic [IRQ_W-1:0] serial_irq_enable,
    output logic irq
);
    // write one to clear; an event in the same cycle wins over the clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            serial_irq_pending <= IRQ_RST;
        end else begin
            serial_irq_pending <= (serial_irq_pending & ~(pend_wr ? wdata[IRQ_W-1:0] : IRQ_RST))
                                | set_ev;
        end
    end

    // enable mask, plain read/write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            serial_irq_enable <= IRQ_RST;
        end else if (en_wr) begin
            serial_irq_enable <= wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(serial_irq_pending & serial_irq_enable);
endmodule : spd_irq_flags

// ==== sim/spd_properties.sv ====
`timescale 1ns/10ps
module spd_properties
    import spd_pkg::*;
#(parameter int AW = 32) (
    input wire logic clk_sys, rstn, psel, penable, pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic mem_req, mem_we, mem_ack, txf_valid, txf_ready, rxf_valid, rxf_ready,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [7:0] mem_wdata, mem_rdata, txf_data, rxf_data,
    input wire logic [1:0] serial_mode_field
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // mode and data path relations, all in the one clock domain
    mode_write_a: assert property (
        psel && penable && pwrite && paddr == OFS_MODE_ONE
        |=> serial_mode_field == $past(pwdata[1:0])) else $error("mode write lost");
    mode_off_a: assert property (
        serial_mode_field == 2'h0 |-> !rxf_ready) else $error("pop while disabled");
    pop_valid_a: assert property (
        rxf_ready |-> rxf_valid) else $error("pop of empty fifo");
    rx_store_a: assert property (
        rxf_ready |=> mem_req && mem_we && mem_wdata == $past(rxf_data))
        else $error("rx byte not stored");
    tx_forward_a: assert property (
        mem_req && mem_ack && !mem_we |=> txf_valid && txf_data == $past(mem_rdata))
        else $error("tx byte not forwarded");
    mem_hold_a: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request moved");
    mem_release_a: assert property (
        mem_req && mem_ack |=> !mem_req) else $error("memory request kept");
    tx_hold_a: assert property (
        txf_valid && !txf_ready |=> txf_valid && $stable(txf_data)) else $error("tx byte dropped");
    // main traffic seen at all
    cover property (mem_req && mem_ack && mem_we);
    cover property (txf_valid && txf_ready);
    cover property (psel && penable && pwrite && paddr == OFS_MODE_ONE);
endmodule : spd_properties
bind spd_serial_dma spd_properties #(.AW(AW)) u_prop (.*);

// ==== sim/spd_partner.sv ====
`timescale 1ns/10ps
module spd_partner #(parameter int AW = 32) (
    input wire logic clk_sys, rstn, mem_req, mem_we, txf_valid, rxf_ready,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [7:0] mem_wdata, txf_data,
    output logic mem_ack, txf_ready, rxf_valid, rxf_perr, rxf_ferr,
    output logic [7:0] mem_rdata, rxf_data
);
    logic [7:0] mem [256]; // all buffers live in this ram
    logic [7:0] txq [$];
    logic [1:0] wait_n;
    logic go;
    int rxn;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    // odd addresses answer slowly; data is scrambled outside the ack cycle
    assign go = mem_req && !mem_ack && wait_n == (mem_addr[0] ? 2'h2 : 2'h0);
    assign mem_rdata = mem_ack ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
    assign rxf_valid = 1'b1;
    assign rxf_data = 8'hC0 + 8'(rxn);
    assign rxf_perr = 1'b0;
    assign rxf_ferr = 1'b0;
    // tx fifo stalls every other cycle
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            wait_n <= 2'h0;
            txf_ready <= 1'b0;
            rxn <= 0;
        end else begin
            mem_ack <= go;
            wait_n <= (mem_req && !mem_ack && !go) ? wait_n + 2'h1 : 2'h0;
            txf_ready <= ~txf_ready;
            if (mem_ack && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
            if (txf_valid && txf_ready) txq.push_back(txf_data);
            if (rxf_ready) rxn <= rxn + 1;
        end
    end
endmodule : spd_partner

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
    import spd_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat, mem_addr;
    logic pready, pslverr, mem_req, mem_we, mem_ack, txf_valid, txf_ready, irq;
    logic rxf_valid, rxf_perr, rxf_ferr, rxf_ready;
    logic [7:0] mem_wdata, mem_rdata, txf_data, rxf_data;
    logic [14:0] sc_event = 15'h0;
    logic [1:0] serial_mode_field;
    int failures = 0, cmp_count = 0;
    spd_serial_dma dut (.*);
    spd_partner pm (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rc(input string n, input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rdat)
    endtask : rc
    function automatic logic [15:0] dma(input logic [7:0] o);
        return DMA_BASE_ONE + {8'h0, o};
    endfunction : dma
    task automatic wait_pend(input logic [31:0] m);
        repeat (300) begin apb(1'b0, OFS_PEND_ONE, 32'h0); if ((rdat & m) === m) break; end
    endtask : wait_pend
    task automatic t_regs;
        rc("pend rst", OFS_PEND_ONE, 32'h0);
        rc("mode rst", OFS_MODE_ONE, 32'h0);
        apb(1'b1, OFS_EN_ONE, 32'hFFFFFFFF);
        rc("enable rw", OFS_EN_ONE, 32'h7FFF);
        apb(1'b0, 16'h0000, 32'h0);
        `CHK("unmapped", 1'b1, err)
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFS_MODE_ONE, 32'(m));
            #1 `CHK("mode", 2'(m), serial_mode_field)
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_irq;
        apb(1'b1, OFS_EN_ONE, 32'h0);
        @(posedge clk_sys) sc_event <= 15'h7FFF;
        @(posedge clk_sys) sc_event <= 15'h0;
        rc("pend ev", OFS_PEND_ONE, 32'h61FF);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, OFS_EN_ONE, 32'h1);
        #1 `CHK("irq on", 1'b1, irq)
        apb(1'b1, OFS_PEND_ONE, 32'h1);
        #1 `CHK("irq clr", 1'b0, irq)
        apb(1'b1, OFS_PEND_ONE, 32'hFFFF);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_tx;
        // reset, buffers, mode, enables, then load
        apb(1'b1, dma(OFS_CTRL), 32'h30);
        apb(1'b1, dma(OFS_TXBEG[0]), 32'h10);
        apb(1'b1, dma(OFS_TXEND[0]), 32'h13);
        apb(1'b1, dma(OFS_TXBEG[1]), 32'h20);
        apb(1'b1, dma(OFS_TXEND[1]), 32'h21);
        apb(1'b1, OFS_MODE_ONE, 32'h2);
        apb(1'b1, OFS_EN_ONE, 32'h1800);
        apb(1'b1, dma(OFS_CTRL), 32'h3);
        wait_pend(32'h1800);
        while (txf_valid) @(posedge clk_sys);
        `CHK("tx unload", 32'h1800, rdat)
        `CHK("tx irq", 1'b1, irq)
        `CHK("tx len", 6, pm.txq.size())
        for (int i = 0; i < 6; i++)
            `CHK("tx byte", (i < 4 ? 8'h10 : 8'h1C) + 8'(i) ^ 8'h5A, pm.txq[i])
        rc("tx offset", dma(OFS_TXCNT), 32'h2);
        apb(1'b1, OFS_PEND_ONE, 32'hFFFF);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx;
        apb(1'b1, dma(OFS_RXBEG[0]), 32'h40);
        apb(1'b1, dma(OFS_RXEND[0]), 32'h42);
        apb(1'b1, dma(OFS_CTRL), 32'h4);
        wait_pend(32'h200);
        repeat (20) @(posedge clk_sys);
        `CHK("rx stall", 3, pm.rxn)
        for (int i = 0; i < 3; i++)
            `CHK("rx byte", 8'hC0 + 8'(i), pm.mem[8'h40 + i])
        rc("rx offset a", dma(OFS_RXCNT[0]), 32'h3);
        apb(1'b1, dma(OFS_RXBEG[1]), 32'h50);
        apb(1'b1, dma(OFS_RXEND[1]), 32'h51);
        apb(1'b1, dma(OFS_RXCNT[1]), 32'h1);
        wait_pend(32'h600);
        `CHK("rx skip", 8'h0A, pm.mem[8'h50])
        `CHK("rx b byte", 8'hC3, pm.mem[8'h51])
        rc("rx offset b", dma(OFS_RXCNT[1]), 32'h2);
        apb(1'b1, OFS_PEND_ONE, 32'hFFFF);
        $display("t_rx done");
    endtask : t_rx
    task automatic t_rst;
        apb(1'b1, OFS_MODE_ONE, 32'h0);
        apb(1'b1, dma(OFS_CTRL), 32'h1);
        rc("tx act", dma(OFS_STAT), 32'h1);
        apb(1'b1, dma(OFS_TXEND[0]), 32'h0F);
        rc("early unload", OFS_PEND_ONE, 32'h800);
        apb(1'b1, OFS_PEND_ONE, 32'hFFFF);
        apb(1'b1, dma(OFS_CTRL), 32'h2);
        apb(1'b1, dma(OFS_CTRL), 32'h30);
        rc("stat clr", dma(OFS_STAT), 32'h0);
        rc("no unload", OFS_PEND_ONE, 32'h0);
        rc("rx cnt clr", dma(OFS_RXCNT[0]), 32'h0);
        $display("t_rst done");
    endtask : t_rst
    task automatic finish_test;
        $display("compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // reset for 16 cycles, then the scenarios in order
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs(); t_irq(); t_tx(); t_rx(); t_rst();
        finish_test();
    end
    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #1000000;
        failures++;
        finish_test();
    end
endmodule : tb
